// ---- rtl/lsbu_pkg.sv ----
// Purpose: Shared constants and types for the logic, shift and bit unit
// Assumes: Operands sized byte, word or longword in a 32-bit datapath
// Notes: Operation codes are supplied by the instruction decoder
package lsbu_pkg;
   localparam int LSBU_DATA_W = 32;
   localparam int LSBU_BITNO_W = 3;
   localparam int LSBU_BYTE_MSB = 7;
   localparam int LSBU_WORD_MSB = 15;
   localparam int LSBU_LONG_MSB = 31;
   localparam logic [31:0] LSBU_RESET_DATA = 32'h0000_0000;
   localparam logic [7:0] LSBU_RESET_BYTE = 8'h00;

   typedef enum logic [1:0] {
      LSBU_SZ_BYTE,
      LSBU_SZ_WORD,
      LSBU_SZ_LONG
   } lsbu_size_t;

   typedef enum logic [5:0] {
      LSBU_OP_AND,
      LSBU_OP_OR,
      LSBU_OP_XOR,
      LSBU_OP_NOT,
      LSBU_OP_SHIFT_ARITH_LEFT,
      LSBU_OP_SHIFT_ARITH_RIGHT,
      LSBU_OP_SHIFT_LOGIC_LEFT,
      LSBU_OP_SHIFT_LOGIC_RIGHT,
      LSBU_OP_ROTATE_LEFT,
      LSBU_OP_ROTATE_RIGHT,
      LSBU_OP_ROTATE_LEFT_VIA_CARRY,
      LSBU_OP_ROTATE_RIGHT_VIA_CARRY,
      LSBU_OP_BIT_FORCE_ONE,
      LSBU_OP_BIT_FORCE_ZERO,
      LSBU_OP_BIT_INVERT,
      LSBU_OP_BIT_CHECK,
      LSBU_OP_CARRY_AND_BIT,
      LSBU_OP_CARRY_AND_INV_BIT,
      LSBU_OP_CARRY_OR_BIT,
      LSBU_OP_CARRY_OR_INV_BIT,
      LSBU_OP_CARRY_XOR_BIT,
      LSBU_OP_CARRY_XOR_INV_BIT,
      LSBU_OP_BIT_TO_CARRY,
      LSBU_OP_INV_BIT_TO_CARRY,
      LSBU_OP_CARRY_TO_BIT,
      LSBU_OP_INV_CARRY_TO_BIT,
      LSBU_OP_TEST_AND_SET_MEM
   } lsbu_op_t;

   typedef enum {
      LSBU_ST_IDLE,
      LSBU_ST_MEM_READ,
      LSBU_ST_MEM_WRITE,
      LSBU_ST_DONE
   } lsbu_state_t;

   // Test-and-set writes this bit of the memory byte
   localparam logic [2:0] LSBU_TAS_BIT = 3'h7;
endpackage

// ---- rtl/lsbu_unit.sv ----
// Purpose: Logic, shift, rotate and single-bit datapath of the CPU
// Assumes: One operation in flight; memory answers with mem_ack
// Notes: Results and flags are registered and shown with done for one cycle
`timescale 1ns/1ns

// Summary of operation
// RULE_01: AND destination with register or immediate
// RULE_02: OR destination with register or immediate
// RULE_03: XOR destination with register or immediate
// RULE_04: Invert every bit of destination within the operand size
// RULE_05: Arithmetic shift left/right by one or two
// RULE_06: Logical shift left/right by one or two
// RULE_07: Rotate left/right without carry, one or two
// RULE_08: Rotate left/right through carry, one or two
// RULE_09: Bit set forces selected byte bit one
// RULE_10: Bit clear forces selected byte bit zero
// RULE_11: Bit invert complements selected byte bit
// RULE_12: Bit test loads zero with inverted bit
// RULE_13: Bit number from immediate or register
// RULE_14: Inverted carry ops use immediate bit number
// RULE_15: Carry becomes carry AND (inverted) bit
// RULE_16: Carry becomes carry OR (inverted) bit
// RULE_17: Carry becomes carry XOR (inverted) bit
// RULE_18: Carry loads selected bit or its inverse
// RULE_19: Selected bit takes carry or its inverse
// RULE_20: Test-and-set address only in four registers
// RULE_21: Shift-out to carry; sign or zero fill
// RULE_22: Memory bit writes are read-modify-write
module lsbu_unit
   import lsbu_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic start,
   input wire lsbu_op_t op,
   input wire lsbu_size_t size,
   input wire logic [31:0] dst_in,
   input wire logic [31:0] src_in,
   input wire logic src_is_imm,
   input wire logic [31:0] imm_in,
   input wire logic [2:0] bitno_imm,
   input wire logic [31:0] bitno_reg,
   input wire logic bitno_from_reg,
   input wire logic mem_operand,
   input wire logic carry_in,
   input wire logic zero_in,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ack,
   output logic busy,
   output logic done,
   output logic [31:0] result,
   output logic result_we,
   output logic carry_out,
   output logic zero_out,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata
);

   typedef struct packed {
      lsbu_state_t st;
      lsbu_op_t op;
      lsbu_size_t size;
      logic [2:0] bitno;
      logic carry;
      logic zero;
      logic [31:0] result;
      logic result_we;
      logic [7:0] wbyte;
   } lsbu_regs_t;

   // Outcome of one bit operation; named fields keep the flag order explicit
   typedef struct packed {
      logic zero;
      logic carry;
      logic [7:0] data;
   } lsbu_bit_res_t;

   // Registered state and its next value; the whole unit moves on one edge
   lsbu_regs_t r;
   lsbu_regs_t next_r;

   // Width-masked operand: bits above the size are kept from the destination
   function automatic logic [31:0] size_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input lsbu_size_t sz);
      logic [31:0] res;
      res = old_v;
      case (sz)
         LSBU_SZ_BYTE: res[LSBU_BYTE_MSB:0] = new_v[LSBU_BYTE_MSB:0];
         LSBU_SZ_WORD: res[LSBU_WORD_MSB:0] = new_v[LSBU_WORD_MSB:0];
         default: res = new_v;
      endcase
      return res;
   endfunction

   // Top bit of the operand at the given size
   function automatic logic msb_of(input logic [31:0] v, input lsbu_size_t sz);
      logic m;
      case (sz)
         LSBU_SZ_BYTE: m = v[LSBU_BYTE_MSB];
         LSBU_SZ_WORD: m = v[LSBU_WORD_MSB];
         default: m = v[LSBU_LONG_MSB];
      endcase
      return m;
   endfunction

   // One single-step shift or rotate; carry gets the bit pushed out
   function automatic logic [32:0] shift_step(input logic [31:0] v, input lsbu_size_t sz,
                                              input lsbu_op_t o, input logic c);
      logic [31:0] n;
      logic co;
      logic top;
      logic fill_l;
      logic fill_r;
      top = msb_of(v, sz);
      n = v;
      co = c;
      fill_l = 1'b0;
      fill_r = 1'b0;
      case (o)
         LSBU_OP_ROTATE_LEFT: fill_l = top;
         LSBU_OP_ROTATE_LEFT_VIA_CARRY: fill_l = c;
         LSBU_OP_SHIFT_ARITH_RIGHT: fill_r = top;
         LSBU_OP_ROTATE_RIGHT: fill_r = v[0];
         LSBU_OP_ROTATE_RIGHT_VIA_CARRY: fill_r = c;
         default: begin
         end
      endcase
      case (o)
         LSBU_OP_SHIFT_ARITH_LEFT, LSBU_OP_SHIFT_LOGIC_LEFT, LSBU_OP_ROTATE_LEFT,
         LSBU_OP_ROTATE_LEFT_VIA_CARRY: begin
            n = {v[30:0], fill_l};
            co = top;
         end
         LSBU_OP_SHIFT_ARITH_RIGHT, LSBU_OP_SHIFT_LOGIC_RIGHT, LSBU_OP_ROTATE_RIGHT,
         LSBU_OP_ROTATE_RIGHT_VIA_CARRY: begin
            n = v >> 1;
            case (sz)
               LSBU_SZ_BYTE: n[LSBU_BYTE_MSB] = fill_r;
               LSBU_SZ_WORD: n[LSBU_WORD_MSB] = fill_r;
               default: n[LSBU_LONG_MSB] = fill_r;
            endcase
            co = v[0];
         end
         default: begin
         end
      endcase
      return {co, n};
   endfunction

   // Byte with one bit replaced
   function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] k,
                                          input logic val);
      logic [7:0] res;
      res = b;
      res[k] = val;
      return res;
   endfunction

   // Inverted carry and inverted store forms; these take only an immediate bit number
   function automatic logic is_inv_imm(input lsbu_op_t o);
      logic f;
      f = (o == LSBU_OP_CARRY_AND_INV_BIT) || (o == LSBU_OP_CARRY_OR_INV_BIT) ||
          (o == LSBU_OP_CARRY_XOR_INV_BIT) || (o == LSBU_OP_INV_BIT_TO_CARRY) ||
          (o == LSBU_OP_INV_CARRY_TO_BIT);
      return f;
   endfunction

   // Operations that write a modified byte back, on the register and the memory path
   function automatic logic is_write_op(input lsbu_op_t o);
      logic f;
      f = (o == LSBU_OP_BIT_FORCE_ONE) || (o == LSBU_OP_BIT_FORCE_ZERO) ||
          (o == LSBU_OP_BIT_INVERT) || (o == LSBU_OP_CARRY_TO_BIT) ||
          (o == LSBU_OP_INV_CARRY_TO_BIT) || (o == LSBU_OP_TEST_AND_SET_MEM);
      return f;
   endfunction

   logic [31:0] src_v;
   logic [2:0] sel_bitno;
   logic is_bit_write;
   logic is_inv_imm_op;

   // Source and bit-number selection
   always_comb begin
      src_v = src_is_imm ? imm_in : src_in;
      is_inv_imm_op = is_inv_imm(op);
      // Inverted forms ignore the register source entirely (see RULE_14)
      if (bitno_from_reg && !is_inv_imm_op) begin
         sel_bitno = bitno_reg[2:0]; // see RULE_13
      end else begin
         sel_bitno = bitno_imm; // see RULE_13
      end
      is_bit_write = is_write_op(op);
   end

   // Computes one operation on a byte; flags it does not own pass through unchanged
   function automatic lsbu_bit_res_t bit_op(input lsbu_op_t o, input logic [7:0] b,
                                            input logic [2:0] k, input logic c, input logic z);
      logic bv;
      logic [7:0] nb;
      logic nc;
      logic nz;
      bv = b[k];
      nb = b;
      nc = c;
      nz = z;
      case (o)
         LSBU_OP_BIT_FORCE_ONE: nb = put_bit(b, k, 1'b1); // see RULE_09
         LSBU_OP_BIT_FORCE_ZERO: nb = put_bit(b, k, 1'b0); // see RULE_10
         LSBU_OP_BIT_INVERT: nb = put_bit(b, k, ~bv); // see RULE_11
         LSBU_OP_BIT_CHECK: nz = ~bv; // see RULE_12
         LSBU_OP_CARRY_AND_BIT: nc = c & bv; // see RULE_15
         LSBU_OP_CARRY_AND_INV_BIT: nc = c & ~bv; // see RULE_15
         LSBU_OP_CARRY_OR_BIT: nc = c | bv; // see RULE_16
         LSBU_OP_CARRY_OR_INV_BIT: nc = c | ~bv; // see RULE_16
         LSBU_OP_CARRY_XOR_BIT: nc = c ^ bv; // see RULE_17
         LSBU_OP_CARRY_XOR_INV_BIT: nc = c ^ ~bv; // see RULE_17
         LSBU_OP_BIT_TO_CARRY: nc = bv; // see RULE_18
         LSBU_OP_INV_BIT_TO_CARRY: nc = ~bv; // see RULE_18
         LSBU_OP_CARRY_TO_BIT: nb = put_bit(b, k, c); // see RULE_19
         LSBU_OP_INV_CARRY_TO_BIT: nb = put_bit(b, k, ~c); // see RULE_19
         LSBU_OP_TEST_AND_SET_MEM: begin
            // Zero reflects the whole byte before bit 7 is set
            nz = (b == LSBU_RESET_BYTE);
            nb = put_bit(b, LSBU_TAS_BIT, 1'b1);
         end
         default: begin
         end
      endcase
      return '{zero: nz, carry: nc, data: nb};
   endfunction

   // Next-state logic for the whole unit
   always_comb begin
      logic [31:0] v;
      logic [32:0] s1;
      logic [32:0] s2;
      lsbu_bit_res_t bres;
      v = LSBU_RESET_DATA;
      s1 = 33'h0_0000_0000;
      s2 = 33'h0_0000_0000;
      bres = '{zero: 1'b0, carry: 1'b0, data: 8'h00};
      // Hold everything by default; the write strobe lives only for the done cycle
      next_r = r;
      next_r.result_we = 1'b0;
      case (r.st)
         LSBU_ST_IDLE: begin
            if (start) begin
               // Operands are taken on this edge only; the decoder may move on after it
               next_r.op = op;
               next_r.size = size;
               next_r.bitno = sel_bitno;
               next_r.carry = carry_in;
               next_r.zero = zero_in;
               if (mem_operand && (op >= LSBU_OP_BIT_FORCE_ONE)) begin
                  // Memory byte is fetched first, then written back by write ops only (see RULE_22)
                  next_r.st = LSBU_ST_MEM_READ;
               end else begin
                  next_r.st = LSBU_ST_DONE;
                  case (op)
                     LSBU_OP_AND: v = size_merge(dst_in, dst_in & src_v, size); // see RULE_01
                     LSBU_OP_OR: v = size_merge(dst_in, dst_in | src_v, size); // see RULE_02
                     LSBU_OP_XOR: v = size_merge(dst_in, dst_in ^ src_v, size); // see RULE_03
                     LSBU_OP_NOT: v = size_merge(dst_in, ~dst_in, size); // see RULE_04
                     default: v = dst_in;
                  endcase
                  if (op >= LSBU_OP_SHIFT_ARITH_LEFT && op <= LSBU_OP_ROTATE_RIGHT_VIA_CARRY) begin
                     // Two-position forms are two single steps (see RULE_05, RULE_06)
                     s1 = shift_step(dst_in, size, op, carry_in); // see RULE_07, RULE_08
                     s2 = src_in[0] ? shift_step(s1[31:0], size, op, s1[32]) : s1;
                     v = size_merge(dst_in, s2[31:0], size);
                     next_r.carry = s2[32]; // see RULE_21
                     next_r.zero = (size_merge(LSBU_RESET_DATA, s2[31:0], size) == 32'h0);
                     next_r.result_we = 1'b1;
                  end else if (op <= LSBU_OP_NOT) begin
                     next_r.zero = (size_merge(LSBU_RESET_DATA, v, size) == 32'h0);
                     next_r.result_we = 1'b1;
                  end else begin
                     // Register bit ops touch only the low byte of the destination
                     bres = bit_op(op, dst_in[7:0], sel_bitno, carry_in, zero_in);
                     next_r.zero = bres.zero;
                     next_r.carry = bres.carry;
                     v = {dst_in[31:8], bres.data};
                     next_r.result_we = is_bit_write;
                  end
                  next_r.result = v;
               end
            end
         end
         LSBU_ST_MEM_READ: begin
            // Read data counts only with its acknowledge; idle bus data is ignored
            if (mem_ack) begin
               bres = bit_op(r.op, mem_rdata, r.bitno, r.carry, r.zero);
               next_r.zero = bres.zero;
               next_r.carry = bres.carry;
               next_r.wbyte = bres.data; // see RULE_22
               next_r.result = {24'h00_0000, mem_rdata};
               if (is_write_op(r.op)) begin
                  next_r.st = LSBU_ST_MEM_WRITE;
               end else begin
                  next_r.st = LSBU_ST_DONE;
               end
            end
         end
         LSBU_ST_MEM_WRITE: begin
            // Strobe and byte stand until memory takes them
            if (mem_ack) begin
               next_r.st = LSBU_ST_DONE;
            end
         end
         LSBU_ST_DONE: begin
            // One-cycle completion; start is ignored here, a new request is taken from the edge after next on
            next_r.st = LSBU_ST_IDLE;
         end
         default: next_r.st = LSBU_ST_IDLE;
      endcase
   end

   // State register; cleared by CPU reset
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         r <= '{st: LSBU_ST_IDLE, op: LSBU_OP_AND, size: LSBU_SZ_BYTE, bitno: 3'h0,
                carry: 1'b0, zero: 1'b0, result: 32'h0000_0000,
                result_we: 1'b0, wbyte: 8'h00};
      end else begin
         r <= next_r;
      end
   end

   // Outputs; the write-enable is held only in the done cycle
   always_comb begin
      busy = (r.st != LSBU_ST_IDLE);
      done = (r.st == LSBU_ST_DONE);
      result = r.result;
      result_we = done && r.result_we;
      carry_out = r.carry;
      zero_out = r.zero;
      mem_rd = (r.st == LSBU_ST_MEM_READ);
      mem_wr = (r.st == LSBU_ST_MEM_WRITE);
      mem_wdata = r.wbyte;
   end
endmodule

// ---- test/lsbu_unit_assertions.sv ----
// Purpose: Concurrent checks on the logic, shift and bit unit
// Assumes: One request in flight; flags valid the edge after a register op
// Notes: Byte values on the memory path are judged by the bench
`timescale 1ns/1ns
module lsbu_unit_checker
   import lsbu_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic start,
   input wire lsbu_op_t op,
   input wire lsbu_size_t size,
   input wire logic [31:0] dst_in,
   input wire logic [31:0] src_in,
   input wire logic [2:0] bitno_imm,
   input wire logic [31:0] bitno_reg,
   input wire logic bitno_from_reg,
   input wire logic mem_operand,
   input wire logic carry_in,
   input wire logic mem_ack,
   input wire logic busy,
   input wire logic done,
   input wire logic [31:0] result,
   input wire logic result_we,
   input wire logic carry_out,
   input wire logic zero_out,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   // A request counts only when taken while idle
   sequence s_take;
      start && !busy;
   endsequence
   sequence s_mem;
      mem_operand && op >= LSBU_OP_BIT_FORCE_ONE;
   endsequence
   property p_reg_done;
      s_take ##0 !(mem_operand && op >= LSBU_OP_BIT_FORCE_ONE) |=> done && busy;
   endproperty
   a_reg_done: assert property (p_reg_done) else $error("register op late");
   property p_mem_read;
      s_take ##0 s_mem |=> mem_rd && !mem_wr && !done;
   endproperty
   a_mem_read: assert property (p_mem_read) else $error("no memory read");
   property p_rd_hold;
      mem_rd && !mem_ack |=> mem_rd;
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read dropped");
   property p_wr_hold;
      mem_wr && !mem_ack |=> mem_wr && $stable(mem_wdata);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write dropped");
   property p_wr_after_rd;
      $rose(mem_wr) |-> $past(mem_rd) && $past(mem_ack);
   endproperty
   a_wr_after_rd: assert property (p_wr_after_rd) else $error("write without read");
   property p_done_pulse;
      done |=> !done && !result_we;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done too long");
   property p_we;
      result_we |-> done && !mem_wr;
   endproperty
   a_we: assert property (p_we) else $error("stray register write");
   property p_bit_one;
      s_take ##0 (op == LSBU_OP_BIT_FORCE_ONE && !mem_operand && !bitno_from_reg)
         |=> result[$past(bitno_imm)];
   endproperty
   a_bit_one: assert property (p_bit_one) else $error("bit not set");
   property p_check_zero;
      s_take ##0 (op == LSBU_OP_BIT_CHECK && !mem_operand && bitno_from_reg)
         |=> zero_out != $past(dst_in[bitno_reg[2:0]]);
   endproperty
   a_check_zero: assert property (p_check_zero) else $error("bad zero");
   property p_rotate_left;
      s_take ##0 (op == LSBU_OP_ROTATE_LEFT && size == LSBU_SZ_BYTE && !src_in[0])
         |=> carry_out == $past(dst_in[7]) && result[0] == $past(dst_in[7]);
   endproperty
   a_rotate_left: assert property (p_rotate_left) else $error("bad rotate");
   property p_inv_and;
      s_take ##0 (op == LSBU_OP_CARRY_AND_INV_BIT && !mem_operand)
         |=> carry_out == ($past(carry_in) && !$past(dst_in[bitno_imm]));
   endproperty
   a_inv_and: assert property (p_inv_and) else $error("bad carry");
endmodule
bind lsbu_unit lsbu_unit_checker lsbu_unit_checker_i (
   .clk_sys(clk_sys), .rstn(rstn), .start(start), .op(op), .size(size),
   .dst_in(dst_in), .src_in(src_in), .bitno_imm(bitno_imm), .bitno_reg(bitno_reg),
   .bitno_from_reg(bitno_from_reg), .mem_operand(mem_operand), .carry_in(carry_in),
   .mem_ack(mem_ack), .busy(busy), .done(done), .result(result), .result_we(result_we),
   .carry_out(carry_out), .zero_out(zero_out), .mem_rd(mem_rd), .mem_wr(mem_wr),
   .mem_wdata(mem_wdata)
);

// ---- test/test_logic_shift_bit_unit.sv ----
// Purpose: Self-checking bench for the logic, shift and bit unit
// Assumes: Memory answers are modelled here with random delay
// Notes: Expected values come from a small model of the operations
`timescale 1ns/1ns
module test_logic_shift_bit_unit;
   import lsbu_pkg::*;
   logic clk_sys = 1'b0, rstn = 1'b0, start = 1'b0, src_is_imm = 1'b0, bitno_from_reg = 1'b0;
   logic mem_operand = 1'b0, carry_in = 1'b0, zero_in = 1'b0, mem_ack = 1'b0;
   lsbu_op_t op = LSBU_OP_AND;
   lsbu_size_t size = LSBU_SZ_BYTE;
   logic [31:0] dst_in = 32'h0, src_in = 32'h0, imm_in = 32'h0, bitno_reg = 32'h0, result;
   logic [2:0] bitno_imm = 3'h0;
   logic [7:0] mem_rdata = 8'h0, mem_wdata;
   logic busy, done, result_we, carry_out, zero_out, mem_rd, mem_wr;
   int err_count = 0, checks_done = 0;
   lsbu_unit lsbu_unit_i (.clk_sys(clk_sys), .rstn(rstn), .start(start), .op(op), .size(size),
      .dst_in(dst_in), .src_in(src_in), .src_is_imm(src_is_imm), .imm_in(imm_in),
      .bitno_imm(bitno_imm), .bitno_reg(bitno_reg), .bitno_from_reg(bitno_from_reg),
      .mem_operand(mem_operand), .carry_in(carry_in), .zero_in(zero_in), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .busy(busy), .done(done), .result(result), .result_we(result_we),
      .carry_out(carry_out), .zero_out(zero_out), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata));
   // Free-running 250 MHz clock
   always #2 clk_sys = ~clk_sys;
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // One request, served and checked; entered and left at a falling edge
   task automatic run_op(lsbu_op_t o, lsbu_size_t sz, logic [31:0] d, logic [31:0] s,
                         logic mem_req, logic [7:0] mb);
      int w, k, i;
      logic [31:0] t, mk;
      logic co, b, m, wr, got_wr;
      logic [7:0] wd, ob, seen_wd;
      op = o;
      size = sz;
      dst_in = d;
      src_in = s;
      imm_in = $urandom;
      src_is_imm = 1'($urandom);
      bitno_imm = 3'($urandom);
      bitno_reg = $urandom;
      bitno_from_reg = 1'($urandom);
      carry_in = 1'($urandom);
      zero_in = 1'($urandom);
      mem_operand = mem_req || o == LSBU_OP_TEST_AND_SET_MEM;
      m = mem_operand && o >= LSBU_OP_BIT_FORCE_ONE;
      // Reference model; inverted carry ops ignore the register bit number
      w = (sz == LSBU_SZ_BYTE) ? 8 : (sz == LSBU_SZ_WORD) ? 16 : 32;
      mk = (w == 32) ? 32'hffffffff : (32'h1 << w) - 32'h1;
      k = (!bitno_from_reg || o inside {LSBU_OP_CARRY_AND_INV_BIT, LSBU_OP_CARRY_OR_INV_BIT,
          LSBU_OP_CARRY_XOR_INV_BIT, LSBU_OP_INV_BIT_TO_CARRY, LSBU_OP_INV_CARRY_TO_BIT})
          ? int'(bitno_imm) : int'(bitno_reg[2:0]);
      ob = m ? mb : d[7:0];
      t = d & mk;
      co = carry_in;
      wd = ob;
      case (o)
         LSBU_OP_AND: t = t & (src_is_imm ? imm_in : s);
         LSBU_OP_OR: t = t | (src_is_imm ? imm_in : s);
         LSBU_OP_XOR: t = t ^ (src_is_imm ? imm_in : s);
         LSBU_OP_NOT: t = ~t;
         LSBU_OP_BIT_FORCE_ONE: wd[k] = 1'b1;
         LSBU_OP_BIT_FORCE_ZERO: wd[k] = 1'b0;
         LSBU_OP_BIT_INVERT: wd[k] = ~ob[k];
         LSBU_OP_BIT_CHECK: co = carry_in;
         LSBU_OP_CARRY_AND_BIT: co = carry_in & ob[k];
         LSBU_OP_CARRY_AND_INV_BIT: co = carry_in & ~ob[k];
         LSBU_OP_CARRY_OR_BIT: co = carry_in | ob[k];
         LSBU_OP_CARRY_OR_INV_BIT: co = carry_in | ~ob[k];
         LSBU_OP_CARRY_XOR_BIT: co = carry_in ^ ob[k];
         LSBU_OP_CARRY_XOR_INV_BIT: co = carry_in ^ ~ob[k];
         LSBU_OP_BIT_TO_CARRY: co = ob[k];
         LSBU_OP_INV_BIT_TO_CARRY: co = ~ob[k];
         LSBU_OP_CARRY_TO_BIT: wd[k] = carry_in;
         LSBU_OP_INV_CARRY_TO_BIT: wd[k] = ~carry_in;
         LSBU_OP_TEST_AND_SET_MEM: wd[7] = 1'b1;
         default:
            for (i = 0; i <= int'(s[0]); i++) begin
               b = (o inside {LSBU_OP_SHIFT_ARITH_LEFT, LSBU_OP_SHIFT_LOGIC_LEFT,
                   LSBU_OP_ROTATE_LEFT, LSBU_OP_ROTATE_LEFT_VIA_CARRY}) ? t[w-1] : t[0];
               case (o)
                  LSBU_OP_SHIFT_ARITH_RIGHT: t = (t >> 1) | (t & (32'h1 << (w - 1)));
                  LSBU_OP_SHIFT_LOGIC_RIGHT: t = t >> 1;
                  LSBU_OP_ROTATE_LEFT: t = (t << 1) | 32'(b);
                  LSBU_OP_ROTATE_RIGHT: t = (t >> 1) | (32'(b) << (w - 1));
                  LSBU_OP_ROTATE_LEFT_VIA_CARRY: t = (t << 1) | 32'(co);
                  LSBU_OP_ROTATE_RIGHT_VIA_CARRY: t = (t >> 1) | (32'(co) << (w - 1));
                  default: t = t << 1;
               endcase
               t = t & mk;
               co = b;
            end
      endcase
      t = t & mk;
      start = 1'b1;
      @(negedge clk_sys);
      if (m && $urandom_range(1) == 1) begin
         // A second request while busy must be ignored
         op = LSBU_OP_NOT;
         @(negedge clk_sys);
      end
      start = 1'b0;
      got_wr = 1'b0;
      seen_wd = 8'h0;
      // Memory answers after a random delay; idle data is the inverse byte
      for (i = 0; i < 40 && done !== 1'b1; i++) begin
         mem_ack = (mem_rd === 1'b1 || mem_wr === 1'b1) && $urandom_range(2) == 0;
         mem_rdata = mem_ack ? mb : ~mb;
         got_wr = got_wr | (mem_ack & mem_wr);
         seen_wd = (mem_ack && mem_wr) ? mem_wdata : seen_wd;
         @(negedge clk_sys);
      end
      mem_ack = 1'b0;
      if (done !== 1'b1) begin
         chk("done", 32'(done), 32'h1);
         finish_test();
      end
      wr = o inside {LSBU_OP_BIT_FORCE_ONE, LSBU_OP_BIT_FORCE_ZERO, LSBU_OP_BIT_INVERT,
           LSBU_OP_CARRY_TO_BIT, LSBU_OP_INV_CARRY_TO_BIT, LSBU_OP_TEST_AND_SET_MEM};
      b = !m && (wr || o < LSBU_OP_BIT_FORCE_ONE);
      chk("result_we", 32'(result_we), 32'(b));
      if (o < LSBU_OP_BIT_FORCE_ONE) begin
         chk("result", result, (d & ~mk) | t);
         chk("zero", 32'(zero_out), 32'(t == 32'h0));
         if (o > LSBU_OP_NOT) chk("carry", 32'(carry_out), 32'(co));
      end else if (wr && m) begin
         chk("mem_wdata", got_wr ? 32'(seen_wd) : 32'(~wd), 32'(wd));
      end else if (wr) begin
         chk("result", result, {d[31:8], wd});
      end else if (o == LSBU_OP_BIT_CHECK) begin
         chk("zero", 32'(zero_out), 32'(!ob[k]));
      end else begin
         chk("carry", 32'(carry_out), 32'(co));
      end
      // Memory ops show the byte that was read
      if (m) chk("mem result", result, {24'h00_0000, mb});
      if (o == LSBU_OP_TEST_AND_SET_MEM) begin
         chk("zero", 32'(zero_out), 32'(mb == 8'h00));
      end
      @(negedge clk_sys);
      chk("done pulse", 32'(done), 32'h0);
   endtask
   // Sweep, random traffic, then a reset in mid-operation
   initial begin
      void'($urandom(71));
      repeat (8) @(negedge clk_sys);
      rstn = 1'b1;
      @(negedge clk_sys);
      for (int o = 0; o <= 26; o++)
         for (int z = 0; z < 6; z++)
            run_op(lsbu_op_t'(o), lsbu_size_t'(z % 3), z < 3 ? 32'h80808081 : $urandom,
                   32'(z / 3), z % 2 == 1, 8'($urandom));
      $display("test sweep done");
      repeat (300)
         run_op(lsbu_op_t'($urandom_range(26)), lsbu_size_t'($urandom_range(2)), $urandom,
                $urandom, 1'($urandom), 8'($urandom));
      $display("test random done");
      op = LSBU_OP_BIT_FORCE_ONE;
      mem_operand = 1'b1;
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
      @(negedge clk_sys);
      rstn = 1'b0;
      @(negedge clk_sys);
      chk("reset", result | 32'({busy, done, result_we, carry_out, zero_out, mem_rd, mem_wr,
          mem_wdata}), 32'h0);
      rstn = 1'b1;
      @(negedge clk_sys);
      run_op(LSBU_OP_XOR, LSBU_SZ_LONG, $urandom, $urandom, 1'b0, 8'h00);
      $display("test reset done");
      finish_test();
   end
endmodule
